// >>> design/dcp_fifo.sv
// Purpose: synchronous valid/ready FIFO
// Assumes: one clock, synchronous reset
// Notes: depth must be a power of two
`timescale 1ns/1ps
`default_nettype none
module dcp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("FIFO depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr;
  logic [AW:0] rdPtr;
  wire logic push = inValid && inReady;
  wire logic pop = outValid && outReady;
  assign inReady = (wrPtr - rdPtr) != (AW+1)'(DEPTH);
  assign outValid = wrPtr != rdPtr;
  assign outData = mem[rdPtr[AW-1:0]];
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr[AW-1:0]] <= inData;
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (push) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= rdPtr + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> design/dcp_host_port.sv
// Purpose: host command port: pointer load, start, block fetch, checks, DMA and status return
// Assumes: port writes and reads are single-cycle strobes synchronous to core_clk
// Notes: drive data enters and leaves through diskRx/diskTx; one FIFO per direction buffers the DMA stream
//
// Summary of operation
// RULE1: Three byte writes build the block pointer
// RULE2: Start write latches config and begins
// RULE3: Host writes start only after setup
// RULE4: Start bit 7 enables completion interrupt
// RULE5: Start bit 6 selects 16-bit transfers
// RULE6: Offset 7 write clears interrupt
// RULE7: Block is sixteen bytes, command first
// RULE8: Unit number must be 0 to 3
// RULE9: Sector number valid up to 094FFH
// RULE10: DMA crosses 64k banks without stopping
// RULE11: Sector range beyond capacity reports error
// RULE12: Odd count forces byte transfers
// RULE13: Odd address forces byte transfers
// RULE14: Address is 16-bit offset plus bank
// RULE15: Unanswered data transfer ends with timeout
// RULE16: Low byte at even address
// RULE17: Codes 00H-03H decoded as listed
// RULE18: 05H-07H decoded, 04H and 16H+ unassigned
// RULE19: 14H and 15H unallocated writes decoded
// RULE20: Status block holds status then config
// RULE21: Status write timeout still completes
// RULE22: Offset 0 read shows busy and interrupt
// RULE23: Active-low interrupt held until cleared
// RULE24: Distinct codes for programming errors
// RULE25: Busy after reset, then ready
// RULE26: Unassigned offsets ignored, reads harmless
`timescale 1ns/1ps
`default_nettype none
module dcp_host_port #(
  parameter int POWERUP_CYCLES = dcp_pkg::POWERUP_CYCLES,
  parameter int TIMEOUT_CYCLES = dcp_pkg::BUS_TIMEOUT_CYCLES,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic portWrite,
  input wire logic portRead,
  input wire logic [2:0] portAddr,
  input wire logic [7:0] portWdata,
  output logic [7:0] portRdata,
  output logic irq_n,
  output dcp_pkg::dcp_mem_req_type memReq,
  input wire dcp_pkg::dcp_mem_rsp_type memRsp,
  input wire logic diskRxValid,
  output logic diskRxReady,
  input wire logic [7:0] diskRxData,
  output logic diskTxValid,
  input wire logic diskTxReady,
  output logic [7:0] diskTxData
);
  initial begin
    if (POWERUP_CYCLES < 1 || TIMEOUT_CYCLES < 1 || FIFO_DEPTH < 2) $error("Bad parameter");
  end

  typedef enum logic [8:0] {
    ST_POWERUP = 9'h001,
    ST_IDLE = 9'h002,
    ST_FETCH = 9'h004,
    ST_CHECK = 9'h008,
    ST_DMA_RD = 9'h010,
    ST_DMA_WR = 9'h020,
    ST_STAT0 = 9'h040,
    ST_STAT1 = 9'h080,
    ST_DONE = 9'h100
  } dcp_state_type;

  dcp_state_type state;
  logic [19:0] blockPointer;
  logic irqEnable;
  logic word16;
  logic irqFlag;
  logic [7:0] blk [dcp_pkg::BLOCK_BYTES];
  logic [3:0] fetchIdx;
  logic [19:0] dmaAddr;
  logic [15:0] dmaLeft;
  logic dmaWord;
  logic [7:0] statusCode;
  logic [31:0] timer;
  logic [7:0] hiHold;
  logic hiPending;

  wire logic busy = state != ST_IDLE;
  wire logic startWrite = portWrite && portAddr == dcp_pkg::OFS_START;
  wire logic clearWrite = portWrite && portAddr == dcp_pkg::OFS_IRQ_CLEAR;
  wire logic [7:0] cmd = blk[dcp_pkg::BLK_COMMAND];
  wire logic [15:0] count = {blk[dcp_pkg::BLK_COUNT1], blk[dcp_pkg::BLK_COUNT0]};
  wire logic [23:0] sector = {blk[dcp_pkg::BLK_SECTOR2], blk[dcp_pkg::BLK_SECTOR1], blk[dcp_pkg::BLK_SECTOR0]};
  // Bank nibble above a 16-bit offset
  wire logic [19:0] ramAddr = {blk[dcp_pkg::BLK_ADDR2][3:0], blk[dcp_pkg::BLK_ADDR1], blk[dcp_pkg::BLK_ADDR0]}; // RULE14
  wire logic [19:0] statAddr = {blk[dcp_pkg::BLK_STAT2][3:0], blk[dcp_pkg::BLK_STAT1], blk[dcp_pkg::BLK_STAT0]};
  // One past the last sector touched; a partial sector counts whole
  wire logic [24:0] lastSector = {1'b0, sector} + 25'({count[15:7]}) + 25'(|count[6:0]);
  wire logic timedOut = timer == 32'(TIMEOUT_CYCLES);
  wire logic isRead = cmd == dcp_pkg::CMD_READ;
  wire logic isWrite = cmd == dcp_pkg::CMD_WRITE || cmd == dcp_pkg::CMD_WRITE_VERIFY
    || cmd == dcp_pkg::CMD_WRITE_UNALLOC || cmd == dcp_pkg::CMD_WRITE_UNALLOC_VERIFY; // RULE19

  // Unassigned codes include 04H, 08H, 09H, 0CH-13H and 16H-FFH
  function automatic logic known_cmd(input logic [7:0] c);
    unique case (c)
      dcp_pkg::CMD_STATUS, dcp_pkg::CMD_READ, dcp_pkg::CMD_CLOSE, dcp_pkg::CMD_CLOSE_VERIFY, // RULE17
      dcp_pkg::CMD_FORMAT, dcp_pkg::CMD_SURFACE, dcp_pkg::CMD_RESTART, // RULE18
      dcp_pkg::CMD_WRITE, dcp_pkg::CMD_WRITE_VERIFY,
      dcp_pkg::CMD_WRITE_UNALLOC, dcp_pkg::CMD_WRITE_UNALLOC_VERIFY: known_cmd = 1'b1; // RULE19
      default: known_cmd = 1'b0;
    endcase
  endfunction

  // Read data is a plain mux; reads change nothing
  always_comb begin
    portRdata = 8'h00;
    if (portAddr == dcp_pkg::OFS_STATUS) begin // RULE26
      portRdata[dcp_pkg::BIT_BUSY] = busy; // RULE22
      portRdata[dcp_pkg::BIT_IRQ] = irqFlag; // RULE22
    end
  end

  // Pointer bytes; odd offsets fall through untouched
  always_ff @(posedge core_clk) begin
    if (srst) begin
      blockPointer <= '0;
    end else if (portWrite) begin
      unique case (portAddr)
        dcp_pkg::OFS_PTR_LOW: blockPointer[7:0] <= portWdata; // RULE1
        dcp_pkg::OFS_PTR_MID: blockPointer[15:8] <= portWdata; // RULE1
        dcp_pkg::OFS_PTR_HIGH: blockPointer[19:16] <= portWdata[3:0]; // RULE1
        default: ; // RULE26
      endcase
    end
  end

  // Start is accepted only when idle; host is expected to poll busy first
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irqEnable <= 1'b0;
      word16 <= 1'b0;
    end else if (startWrite && state == ST_IDLE) begin
      irqEnable <= portWdata[dcp_pkg::BIT_IRQ_ENABLE]; // RULE4
      word16 <= portWdata[dcp_pkg::BIT_WORD16]; // RULE5
    end
  end

  // Completion sets the flag; a same-cycle clear loses to it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irqFlag <= 1'b0;
    end else if (state == ST_DONE && irqEnable) begin
      irqFlag <= 1'b1; // RULE4 RULE21
    end else if (clearWrite || startWrite) begin
      irqFlag <= 1'b0; // RULE6 RULE23
    end
  end
  assign irq_n = ~irqFlag; // RULE23

  // Two FIFOs between drive streams and memory, one per direction
  logic rxOutValid;
  logic rxOutReady;
  logic [7:0] rxOutData;
  logic txInValid;
  logic txInReady;
  logic [7:0] txInData;
  dcp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .core_clk(core_clk), .srst(srst),
    .inValid(diskRxValid), .inReady(diskRxReady), .inData(diskRxData),
    .outValid(rxOutValid), .outReady(rxOutReady), .outData(rxOutData)
  );
  dcp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .core_clk(core_clk), .srst(srst),
    .inValid(txInValid), .inReady(txInReady), .inData(txInData),
    .outValid(diskTxValid), .outReady(diskTxReady), .outData(diskTxData)
  );

  // Memory request acknowledged: a fetch, DMA or status access completes
  wire logic memDone = memReq.req && memRsp.ack;
  // Every byte taken pops once, the held low byte and its partner alike
  assign rxOutReady = state == ST_DMA_RD && !memReq.req && rxOutValid;
  assign txInValid = state == ST_DMA_WR && (hiPending || memDone);
  assign txInData = hiPending ? hiHold : (memReq.addr[0] ? memRsp.rdata[15:8] : memRsp.rdata[7:0]);

  // Main sequencer
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= ST_POWERUP; // RULE25
      timer <= '0;
      fetchIdx <= '0;
      memReq <= '0;
      dmaAddr <= '0;
      dmaLeft <= '0;
      dmaWord <= 1'b0;
      statusCode <= dcp_pkg::ST_OK;
      hiHold <= 8'h00;
      hiPending <= 1'b0;
      // Cleared at reset only; a fetch aborted later keeps bytes of the previous block
      for (int i = 0; i < dcp_pkg::BLOCK_BYTES; i++) begin
        blk[i] <= 8'h00;
      end
    end else begin
      // One counter serves bus waits and the power-up delay
      timer <= (memReq.req && !memDone) ? timer + 32'd1 : 32'd0;
      unique case (state)
        ST_POWERUP: begin
          timer <= timer + 32'd1;
          if (timer == 32'(POWERUP_CYCLES - 1)) begin
            timer <= '0;
            state <= ST_IDLE; // RULE25
          end
        end
        ST_IDLE: begin
          if (startWrite) begin
            fetchIdx <= '0;
            statusCode <= dcp_pkg::ST_OK;
            memReq <= '{req: 1'b1, write: 1'b0, word: 1'b0, addr: blockPointer, wdata: 16'h0000}; // RULE2
            state <= ST_FETCH; // RULE2
          end
        end
        ST_FETCH: begin
          if (memDone) begin
            blk[fetchIdx] <= memReq.addr[0] ? memRsp.rdata[15:8] : memRsp.rdata[7:0]; // RULE7
            fetchIdx <= fetchIdx + 4'd1;
            memReq.addr <= memReq.addr + 20'd1;
            if (fetchIdx == 4'(dcp_pkg::BLOCK_BYTES - 1)) begin
              memReq.req <= 1'b0;
              state <= ST_CHECK;
            end
          end else if (timedOut) begin
            memReq.req <= 1'b0;
            statusCode <= dcp_pkg::ST_BUS_TIMEOUT;
            // No trusted status pointer yet, so no status block
            state <= ST_DONE;
          end
        end
        ST_CHECK: begin
          dmaAddr <= ramAddr;
          dmaLeft <= count;
          // Any odd start or odd count keeps the whole transfer byte-wide
          dmaWord <= word16 && !count[0] && !ramAddr[0]; // RULE12 RULE13
          if (!known_cmd(cmd)) begin
            statusCode <= dcp_pkg::ST_BAD_COMMAND; // RULE24
            state <= ST_STAT0;
          end else if (blk[dcp_pkg::BLK_UNIT] > dcp_pkg::MAX_UNIT) begin
            statusCode <= dcp_pkg::ST_BAD_UNIT; // RULE8 RULE24
            state <= ST_STAT0;
          end else if (sector > dcp_pkg::MAX_SECTOR
              || ((isRead || isWrite) && lastSector > {1'b0, dcp_pkg::MAX_SECTOR} + 25'd1)) begin
            statusCode <= dcp_pkg::ST_BAD_SECTOR; // RULE9 RULE11 RULE24
            state <= ST_STAT0;
          end else if (isRead && count != 16'h0000) begin
            state <= ST_DMA_RD;
          end else if (isWrite && count != 16'h0000) begin
            state <= ST_DMA_WR;
          end else begin
            state <= ST_STAT0;
          end
        end
        ST_DMA_RD: begin
          // Drive data to memory
          if (memDone) begin
            memReq.req <= 1'b0;
            dmaAddr <= dmaAddr + (memReq.word ? 20'd2 : 20'd1); // RULE10
            dmaLeft <= dmaLeft - (memReq.word ? 16'd2 : 16'd1);
            if (dmaLeft == (memReq.word ? 16'd2 : 16'd1)) begin
              state <= ST_STAT0;
            end
          end else if (timedOut) begin
            memReq.req <= 1'b0;
            statusCode <= dcp_pkg::ST_BUS_TIMEOUT; // RULE15
            state <= ST_STAT0;
          end else if (!memReq.req && rxOutValid) begin
            // Low byte waits in hiHold until its partner arrives
            if (dmaWord && !hiPending) begin
              hiHold <= rxOutData;
              hiPending <= 1'b1;
            end else if (!dmaWord) begin
              memReq <= '{req: 1'b1, write: 1'b1, word: 1'b0, addr: dmaAddr, wdata: {8'h00, rxOutData}};
            end else begin
              hiPending <= 1'b0;
              // First byte goes to the even address
              memReq <= '{req: 1'b1, write: 1'b1, word: 1'b1, addr: dmaAddr, wdata: {rxOutData, hiHold}}; // RULE16
            end
          end
        end
        ST_DMA_WR: begin
          // Memory data to drive; the high byte waits one slot in hiHold
          if (hiPending) begin
            if (txInReady) begin
              hiPending <= 1'b0;
            end
          end else if (memDone) begin
            memReq.req <= 1'b0;
            if (memReq.word) begin
              hiHold <= memRsp.rdata[15:8]; // RULE16
              hiPending <= 1'b1;
            end
            dmaAddr <= dmaAddr + (memReq.word ? 20'd2 : 20'd1); // RULE10
            dmaLeft <= dmaLeft - (memReq.word ? 16'd2 : 16'd1);
          end else if (timedOut) begin
            memReq.req <= 1'b0;
            statusCode <= dcp_pkg::ST_BUS_TIMEOUT; // RULE15
            state <= ST_STAT0;
          end else if (!memReq.req && dmaLeft == 16'h0000) begin
            state <= ST_STAT0;
          // Issue only with FIFO room, so an answer is never dropped
          end else if (!memReq.req && txInReady) begin
            memReq <= '{req: 1'b1, write: 1'b0, word: dmaWord, addr: dmaAddr, wdata: 16'h0000};
          end
        end
        ST_STAT0: begin
          hiPending <= 1'b0;
          if (!memReq.req) begin
            memReq <= '{req: 1'b1, write: 1'b1, word: 1'b0, addr: statAddr, wdata: {8'h00, statusCode}}; // RULE20
          end else if (memDone || timedOut) begin
            memReq <= '{req: 1'b1, write: 1'b1, word: 1'b0, addr: statAddr + 20'd1,
              wdata: {8'h00, dcp_pkg::CONFIG_CODE}}; // RULE20
            state <= memDone ? ST_STAT1 : ST_DONE; // RULE21
            // Config byte is skipped once the status write timed out
            if (timedOut) begin
              memReq.req <= 1'b0;
            end
          end
        end
        ST_STAT1: begin
          if (memDone || timedOut) begin
            memReq.req <= 1'b0;
            state <= ST_DONE; // RULE21
          end
        end
        ST_DONE: begin
          // Flag is set here; busy falls on the same edge
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> design/dcp_pkg.sv
// Purpose: shared constants and types for the disk controller host command port
// Assumes: byte-wide port writes, single clock core_clk at 125 MHz
// Notes: memory side is a simple request/acknowledge master with timeout
package dcp_pkg;
  localparam logic [2:0] OFS_STATUS = 3'h0;
  localparam logic [2:0] OFS_PTR_LOW = 3'h0;
  localparam logic [2:0] OFS_PTR_MID = 3'h2;
  localparam logic [2:0] OFS_PTR_HIGH = 3'h4;
  localparam logic [2:0] OFS_START = 3'h6;
  localparam logic [2:0] OFS_IRQ_CLEAR = 3'h7;
  localparam int BIT_BUSY = 7;
  localparam int BIT_IRQ = 6;
  localparam int BIT_IRQ_ENABLE = 7;
  localparam int BIT_WORD16 = 6;
  localparam int BLOCK_BYTES = 16;
  localparam logic [3:0] BLK_COMMAND = 4'h0;
  localparam logic [3:0] BLK_UNIT = 4'h1;
  localparam logic [3:0] BLK_SECTOR0 = 4'h2;
  localparam logic [3:0] BLK_SECTOR1 = 4'h3;
  localparam logic [3:0] BLK_SECTOR2 = 4'h4;
  localparam logic [3:0] BLK_COUNT0 = 4'h6;
  localparam logic [3:0] BLK_COUNT1 = 4'h7;
  localparam logic [3:0] BLK_ADDR0 = 4'h8;
  localparam logic [3:0] BLK_ADDR1 = 4'h9;
  localparam logic [3:0] BLK_ADDR2 = 4'hA;
  localparam logic [3:0] BLK_STAT0 = 4'hC;
  localparam logic [3:0] BLK_STAT1 = 4'hD;
  localparam logic [3:0] BLK_STAT2 = 4'hE;
  localparam logic [7:0] MAX_UNIT = 8'h03;
  localparam logic [23:0] MAX_SECTOR = 24'h0094FF;
  localparam logic [7:0] CMD_STATUS = 8'h00;
  localparam logic [7:0] CMD_READ = 8'h01;
  localparam logic [7:0] CMD_CLOSE = 8'h02;
  localparam logic [7:0] CMD_CLOSE_VERIFY = 8'h03;
  localparam logic [7:0] CMD_FORMAT = 8'h05;
  localparam logic [7:0] CMD_SURFACE = 8'h06;
  localparam logic [7:0] CMD_RESTART = 8'h07;
  localparam logic [7:0] CMD_WRITE = 8'h0A;
  localparam logic [7:0] CMD_WRITE_VERIFY = 8'h0B;
  localparam logic [7:0] CMD_WRITE_UNALLOC = 8'h14;
  localparam logic [7:0] CMD_WRITE_UNALLOC_VERIFY = 8'h15;
  localparam logic [7:0] ST_OK = 8'h80;
  localparam logic [7:0] ST_BAD_UNIT = 8'h11;
  localparam logic [7:0] ST_BAD_SECTOR = 8'h12;
  localparam logic [7:0] ST_BAD_ADDRESS = 8'h13;
  localparam logic [7:0] ST_BAD_COMMAND = 8'h14;
  localparam logic [7:0] ST_BUS_TIMEOUT = 8'h24;
  localparam logic [7:0] CONFIG_CODE = 8'h00;
  localparam int CLK_MHZ = 125;
  localparam int POWERUP_MS = 1000;
  localparam int POWERUP_CYCLES = POWERUP_MS * 1000 * CLK_MHZ;
  localparam int BUS_TIMEOUT_US = 10;
  localparam int BUS_TIMEOUT_CYCLES = BUS_TIMEOUT_US * CLK_MHZ;

  typedef struct packed {
    logic req;
    logic write;
    logic word;
    logic [19:0] addr;
    logic [15:0] wdata;
  } dcp_mem_req_type;

  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
  } dcp_mem_rsp_type;
endpackage

// >>> verif/dcp_host_port_sva.sv
// Purpose: port-level checks for the host command port
// Assumes: one clock domain, bound to dcp_host_port
// Notes: busy is seen only through offset-0 reads, so start checks need an observed idle
`timescale 1ns/1ps
`default_nettype none
module dcp_host_port_sva #(
  parameter int POWERUP_CYCLES = 20,
  parameter int TIMEOUT_CYCLES = 16
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic portWrite,
  input wire logic [2:0] portAddr,
  input wire logic [7:0] portWdata,
  input wire logic [7:0] portRdata,
  input wire logic irq_n,
  input wire dcp_pkg::dcp_mem_req_type memReq,
  input wire dcp_pkg::dcp_mem_rsp_type memRsp
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic [19:0] ptr;
  logic [19:0] addrQ;
  logic knownIdle;
  logic clrWr;
  logic stRd;
  int upCnt;
  int waitCnt;
  assign clrWr = portWrite && (portAddr == dcp_pkg::OFS_IRQ_CLEAR || portAddr == dcp_pkg::OFS_START);
  assign stRd = portAddr == dcp_pkg::OFS_STATUS;
  always_ff @(posedge core_clk) begin
    if (portWrite && portAddr == dcp_pkg::OFS_PTR_LOW) ptr[7:0] <= portWdata;
    if (portWrite && portAddr == dcp_pkg::OFS_PTR_MID) ptr[15:8] <= portWdata;
    if (portWrite && portAddr == dcp_pkg::OFS_PTR_HIGH) ptr[19:16] <= portWdata[3:0];
  end
  // Busy rises only by a start, so an idle seen once holds until the next start
  always_ff @(posedge core_clk) begin
    if (srst || (portWrite && portAddr == dcp_pkg::OFS_START)) knownIdle <= 1'b0;
    else if (stRd) knownIdle <= !portRdata[7];
  end
  always_ff @(posedge core_clk) begin
    if (srst) upCnt <= 0;
    else if (upCnt < POWERUP_CYCLES) upCnt <= upCnt + 1;
  end
  always_ff @(posedge core_clk) begin
    addrQ <= memReq.addr;
    if (srst || !memReq.req || memRsp.ack || memReq.addr != addrQ) waitCnt <= 0;
    else waitCnt <= waitCnt + 1;
  end
  AST_START: assert property (
    portWrite && portAddr == dcp_pkg::OFS_START && knownIdle
    |=> memReq.req && !memReq.write && memReq.addr == ptr && (!stRd || portRdata[7]))
    else $error("start did not fetch at the loaded pointer");
  AST_HOLD: assert property (
    memReq.req && !memRsp.ack && waitCnt < TIMEOUT_CYCLES - 2 |=> memReq.req && $stable(memReq))
    else $error("memory request changed before its answer");
  AST_TMO: assert property (waitCnt <= TIMEOUT_CYCLES + 1)
    else $error("memory request outlived the bus timeout");
  AST_CLEAR: assert property (clrWr && knownIdle |=> irq_n)
    else $error("interrupt not cleared by port write");
  AST_LEVEL: assert property (!irq_n && !clrWr |=> !irq_n)
    else $error("interrupt released without a clearing write");
  AST_STAT: assert property (stRd |-> portRdata[6] == !irq_n && portRdata[5:0] == 6'h00)
    else $error("status byte does not match interrupt line");
  AST_QUIET: assert property (!stRd |-> portRdata == 8'h00)
    else $error("unassigned offset reads nonzero");
  AST_WORD: assert property (memReq.req && memReq.word |-> !memReq.addr[0])
    else $error("word transfer at odd address");
  AST_POWERUP: assert property (upCnt < POWERUP_CYCLES - 2 |-> irq_n && !memReq.req && (!stRd || portRdata[7]))
    else $error("not busy and quiet during power-up");
  COV_IRQ: cover property ($fell(irq_n));
  COV_WORD: cover property (memReq.req && memReq.word && memRsp.ack);
  COV_TMO: cover property (waitCnt == TIMEOUT_CYCLES);
endmodule
bind dcp_host_port dcp_host_port_sva #(.POWERUP_CYCLES(POWERUP_CYCLES), .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_sva (
  .core_clk, .srst, .portWrite, .portAddr, .portWdata, .portRdata, .irq_n, .memReq, .memRsp);
`default_nettype wire

// >>> verif/dcp_mem_model.sv
// Purpose: system memory answering the DMA master
// Assumes: one request at a time, ack is a single-cycle pulse
// Notes: addresses at or above HOLE never answer, to provoke bus timeouts
`timescale 1ns/1ps
`default_nettype none
module dcp_mem_model #(
  parameter logic [19:0] HOLE = 20'hF0000
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire dcp_pkg::dcp_mem_req_type memReq,
  output var dcp_pkg::dcp_mem_rsp_type memRsp
);
  logic [7:0] mem [int];
  int wordCount = 0;
  int waitLeft = 0;
  function automatic logic [7:0] peek(int a);
    return mem.exists(a) ? mem[a] : 8'(a) ^ 8'h5A;
  endfunction
  initial memRsp = '0;
  always @(posedge core_clk) begin
    memRsp.ack <= 1'b0;
    // Idle bus data keeps toggling so stale data is never mistaken for an answer
    memRsp.rdata <= ~memRsp.rdata;
    if (srst) begin
      waitLeft <= 0;
    end else if (memReq.req && !memRsp.ack && memReq.addr < HOLE) begin
      if (waitLeft > 0) begin
        waitLeft <= waitLeft - 1;
      end else begin
        memRsp.ack <= 1'b1;
        waitLeft <= $urandom % 6;
        memRsp.rdata <= {peek(int'({memReq.addr[19:1], 1'b1})), peek(int'({memReq.addr[19:1], 1'b0}))};
        if (memReq.word) wordCount <= wordCount + 1;
        if (memReq.write && memReq.word) begin
          mem[int'({memReq.addr[19:1], 1'b0})] = memReq.wdata[7:0];
          mem[int'({memReq.addr[19:1], 1'b1})] = memReq.wdata[15:8];
        end else if (memReq.write) begin
          mem[int'(memReq.addr)] = memReq.wdata[7:0];
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> verif/tb.sv
// Purpose: self-checking bench for the host command port
// Assumes: shortened power-up and bus timeout counts
// Notes: drive streams stall at random so the FIFO fills and drains
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [19:0] SB = 20'h40000;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic portWrite = 1'b0;
  logic [2:0] portAddr = 3'h0;
  logic [7:0] portWdata = 8'h00;
  logic [7:0] portRdata;
  logic irq_n;
  dcp_pkg::dcp_mem_req_type memReq;
  dcp_pkg::dcp_mem_rsp_type memRsp;
  logic rxOn = 1'b0;
  logic rxValid = 1'b0;
  logic rxReady;
  logic [7:0] rxData = 8'h00;
  logic txValid;
  logic txReady = 1'b0;
  logic [7:0] txData;
  logic [7:0] rxQ [$];
  logic [7:0] txQ [$];
  logic [7:0] okCmd [6] = '{8'h00, 8'h02, 8'h03, 8'h05, 8'h06, 8'h07};
  logic [7:0] badCmd [4] = '{8'h04, 8'h16, 8'h80, 8'hFF};
  int bad_count = 0;
  int checks_done = 0;
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin bad_count++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end
  initial forever #4 core_clk = ~core_clk;
  dcp_host_port #(.POWERUP_CYCLES(20), .TIMEOUT_CYCLES(16), .FIFO_DEPTH(16)) i_dut (
    .core_clk(core_clk), .srst(srst), .portWrite(portWrite), .portRead(1'b0), .portAddr(portAddr),
    .portWdata(portWdata), .portRdata(portRdata), .irq_n(irq_n), .memReq(memReq), .memRsp(memRsp),
    .diskRxValid(rxValid), .diskRxReady(rxReady), .diskRxData(rxData),
    .diskTxValid(txValid), .diskTxReady(txReady), .diskTxData(txData));
  dcp_mem_model i_mem (.core_clk(core_clk), .srst(srst), .memReq(memReq), .memRsp(memRsp));
  always @(posedge core_clk) begin
    if (rxValid && rxReady) rxQ.push_back(rxData);
    if (!rxValid || rxReady) begin
      rxValid <= rxOn && $urandom % 2;
      rxData <= 8'($urandom);
    end
    if (txValid && txReady) txQ.push_back(txData);
    txReady <= ($urandom % 3) == 0;
  end
  function automatic logic exp_word(input logic [7:0] cfg, input logic [15:0] cnt, input logic [19:0] adr);
    return cfg[dcp_pkg::BIT_WORD16] && !cnt[0] && !adr[0];
  endfunction
  task automatic test_done();
    if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    portWrite <= 1'b1;
    portAddr <= a;
    portWdata <= d;
    @(posedge core_clk);
    portWrite <= 1'b0;
    portAddr <= dcp_pkg::OFS_STATUS;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (portRdata[7] !== 1'b0 && n < 3000);
    `CHK("idle", 1'b1, n < 3000)
  endtask
  task automatic run(input logic [7:0] cmd, unit, input logic [23:0] sec, input logic [15:0] cnt,
      input logic [19:0] adr, status_block_pointer, input logic [7:0] cfg, st);
    logic [19:0] p;
    logic [7:0] blk [16];
    int i;
    p = 20'h50000 | 20'($urandom % 4096) << 4;
    blk = '{cmd, unit, sec[7:0], sec[15:8], sec[23:16], 8'h00, cnt[7:0], cnt[15:8], adr[7:0], adr[15:8],
      8'(adr[19:16]), 8'h00, status_block_pointer[7:0], status_block_pointer[15:8], 8'(status_block_pointer[19:16]), 8'h00};
    foreach (blk[k]) i_mem.mem[int'(p) + k] = blk[k];
    for (i = 0; i < int'(cnt); i++) i_mem.mem[int'(adr) + i] = 8'($urandom);
    i_mem.mem[int'(status_block_pointer)] = 8'hEE;
    i_mem.mem[int'(status_block_pointer) + 1] = 8'hEE;
    txQ.delete();
    rxQ.delete();
    i_mem.wordCount = 0;
    rxOn = cmd == dcp_pkg::CMD_READ;
    wait_idle();
    wr(dcp_pkg::OFS_PTR_LOW, p[7:0]);
    wr(3'h1, ~p[7:0]);
    wr(dcp_pkg::OFS_PTR_MID, p[15:8]);
    wr(3'h3, 8'hFF);
    wr(dcp_pkg::OFS_PTR_HIGH, 8'(p[19:16]));
    wr(3'h5, 8'hFF);
    wr(dcp_pkg::OFS_START, cfg);
    wait_idle();
    if (status_block_pointer < 20'hF0000) begin
      `CHK("status", st, i_mem.mem[int'(status_block_pointer)])
      `CHK("config", dcp_pkg::CONFIG_CODE, i_mem.mem[int'(status_block_pointer) + 1])
    end
    `CHK("irq", ~cfg[7], irq_n)
    if (st == dcp_pkg::ST_OK && cnt != 0) begin
      for (i = 0; txQ.size() < int'(cnt) && cmd != dcp_pkg::CMD_READ && i < 3000; i++) @(negedge core_clk);
      for (i = 0; i < int'(cnt); i++) begin
        if (cmd == dcp_pkg::CMD_READ) `CHK("rdata", rxQ[i], i_mem.mem[int'(adr) + i])
        else `CHK("tdata", i_mem.mem[int'(adr) + i], txQ[i])
      end
      `CHK("word", exp_word(cfg, cnt, adr), i_mem.wordCount != 0)
    end
    wr(dcp_pkg::OFS_IRQ_CLEAR, 8'($urandom));
    @(negedge core_clk);
    `CHK("clear", 1'b1, irq_n)
  endtask
  initial begin
    repeat (60000) @(posedge core_clk);
    bad_count++;
    test_done();
  end
  initial begin
    void'($urandom(32'h43c85739));
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    @(negedge core_clk);
    `CHK("powerup", 2'b11, {portRdata[7], irq_n})
    run(dcp_pkg::CMD_WRITE, 8'h00, 24'h10, 16'd32, 20'h10100 | 20'($urandom % 256) * 2, SB, 8'hC0, 8'h80);
    run(dcp_pkg::CMD_WRITE_VERIFY, 8'h01, 24'h200, 16'd7, 20'h11000, SB, 8'h40, dcp_pkg::ST_OK);
    run(dcp_pkg::CMD_WRITE_UNALLOC, 8'h02, 24'h94FF, 16'd128, 20'h12001, SB, 8'hC0, dcp_pkg::ST_OK);
    run(dcp_pkg::CMD_WRITE_UNALLOC_VERIFY, 8'h03, 24'h5, 16'd8, 20'h2FFFC, SB, 8'hC0, dcp_pkg::ST_OK);
    run(dcp_pkg::CMD_READ, 8'h00, 24'h5, 16'd6, 20'h1FFFE, SB, 8'hC0, dcp_pkg::ST_OK);
    foreach (okCmd[k]) run(okCmd[k], 8'h01, 24'h0, 16'd0, 20'h14000, SB, 8'($urandom) & 8'h80, 8'h80);
    foreach (badCmd[k]) run(badCmd[k], 8'h07, 24'h0, 16'd2, 20'h14000, SB, 8'h80, 8'h14);
    run(dcp_pkg::CMD_WRITE, 8'h04 + 8'($urandom % 252), 24'h0, 16'd2, 20'h14000, SB, 8'h00, 8'h11);
    run(dcp_pkg::CMD_WRITE, 8'h00, 24'h9500, 16'd2, 20'h14000, SB, 8'h80, 8'h12);
    run(dcp_pkg::CMD_WRITE, 8'h00, 24'h94FF, 16'd129, 20'h14000, SB, 8'h80, 8'h12);
    run(dcp_pkg::CMD_WRITE, 8'h00, 24'h0, 16'd4, 20'hF0010, SB, 8'h80, dcp_pkg::ST_BUS_TIMEOUT);
    run(dcp_pkg::CMD_WRITE, 8'h00, 24'h0, 16'd4, 20'h13000, 20'hF8000, 8'h80, 8'h80);
    test_done();
  end
endmodule
`default_nettype wire
